/* File: exec_pkg.sv */
// constants, encodings and carriers shared by the execute block
// assumes a single 20 MHz clock; one clock per instruction phase
//
// Notes on behaviour
// RQ1 - add-with-carry sums accumulator, carry and file byte; opcode 0010 00da
// RQ2 - add-with-carry updates sign, signed wrap, carry, half carry, zero
// RQ3 - destination bit one writes the file byte, zero the accumulator
// RQ4 - bank bit zero uses the access bank, one uses the bank select register
// RQ5 - extended set, bank bit zero, file address <= 5Fh: indexed literal offset
// RQ6 - and-immediate ANDs accumulator with literal into accumulator; 0000 1011
// RQ7 - and-with-file ANDs accumulator with file byte to destination; 0001 01da
// RQ8 - both AND forms change only sign and zero flags
// RQ9 - branch on carry set (1110 0010) jumps only when carry is one
// RQ10 - branch on sign set (1110 0110) jumps only when sign flag is one
// RQ11 - taken branch target is instruction address plus two plus twice offset
// RQ12 - branch takes one cycle untaken, two taken; second cycle does nothing
// RQ13 - clear-file-bit forces bit b (0..7) of file byte to zero; 1001 bbba
// RQ14 - branches and clear-file-bit leave all status flags unchanged
// RQ15 - each cycle runs decode, operand read, process, write in four phases
package exec_pkg;

    // register port byte offsets
    localparam logic [7:0] OFS_ACC = 8'h00;
    localparam logic [7:0] OFS_BANK = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_INDEX = 8'h14;
    localparam logic [7:0] OFS_STATE = 8'h18;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic [20:0] PC_RST = 21'h00_0000;
    localparam logic [11:0] INDEX_RST = 12'h000;

    // status bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_HALF = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_WRAP = 3;
    localparam int FLAG_N = 4;

    // control register bit
    localparam int CTRL_EXT = 0;

    // opcode patterns
    localparam logic [5:0] OP_ADDC_FILE = 6'h08;
    localparam logic [7:0] OP_AND_IMM = 8'h0B;
    localparam logic [5:0] OP_AND_FILE = 6'h05;
    localparam logic [7:0] OP_BR_CARRY = 8'hE2;
    localparam logic [7:0] OP_BR_SIGN = 8'hE6;
    localparam logic [3:0] OP_CLR_BIT = 4'h9;

    // addressing
    localparam logic [7:0] INDEX_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] SFR_BANK = 4'hF;
    localparam logic [20:0] PC_STEP = 21'h00_0002;

    typedef enum logic [2:0] {
        PH_DECODE = 3'b000,
        PH_READ = 3'b001,
        PH_PROCESS = 3'b010,
        PH_WRITE = 3'b011,
        PH_IDLE = 3'b100
    } phase_t;

    typedef enum logic [2:0] {
        OPK_NONE = 3'b000,
        OPK_ADDC = 3'b001,
        OPK_ANDI = 3'b010,
        OPK_ANDF = 3'b011,
        OPK_BRANCH = 3'b100,
        OPK_CLRBIT = 3'b101
    } op_kind_t;

    typedef struct packed {
        logic [11:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } dmem_req_t;

endpackage

/* File: alu_branch_bitclear_exec.sv */
// execute unit for add-with-carry, AND, carry/sign branches and bit clear
// assumes instruction words arrive on instr when instr_ready is high, and
// data memory answers a read strobe with dmem_rdata in the next cycle
`timescale 1ns/100ps
`default_nettype none

module alu_branch_bitclear_exec
    import exec_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int PC_W = 21
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic [PC_W-1:0] prog_addr,
    output dmem_req_t dmem_req,
    input wire logic [7:0] dmem_rdata,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic unknown_op
);

    // elaboration stops on widths that the datapath cannot serve
    if (ADDR_W != 12 || PC_W < 9 || PC_W > 21) begin : g_bad_width
        $error("exec: ADDR_W must be 12 and PC_W 9..21");
    end

    // architectural state
    logic [7:0] acc_r, acc_nxt;
    logic [3:0] bank_r, bank_nxt;
    logic [4:0] status_r, status_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic ext_r, ext_nxt;
    logic [11:0] index_r, index_nxt;

    // pipeline state
    phase_t phase_r, phase_nxt;
    logic nop_r, nop_nxt;
    logic [15:0] ir_r, ir_nxt;
    op_kind_t kind_r, kind_nxt;
    logic [PC_W-1:0] here_r, here_nxt;
    logic [7:0] res_r, res_nxt;
    logic [4:0] flags_r, flags_nxt;
    logic take_r, take_nxt;

    // outputs
    logic ready_r, ready_nxt;
    dmem_req_t dreq_r, dreq_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic unk_r, unk_nxt;

    // combinational decode of the incoming word
    op_kind_t dec_kind;
    logic [11:0] dec_addr;
    logic [7:0] f_field;

    always_comb begin
        f_field = instr[7:0];
        if (instr[15:10] == OP_ADDC_FILE) begin
            dec_kind = OPK_ADDC; // RQ1
        end else if (instr[15:8] == OP_AND_IMM) begin
            dec_kind = OPK_ANDI; // RQ6
        end else if (instr[15:10] == OP_AND_FILE) begin
            dec_kind = OPK_ANDF; // RQ7
        end else if (instr[15:8] == OP_BR_CARRY ||
                     instr[15:8] == OP_BR_SIGN) begin
            dec_kind = OPK_BRANCH; // RQ9 RQ10
        end else if (instr[15:12] == OP_CLR_BIT) begin
            dec_kind = OPK_CLRBIT; // RQ13
        end else begin
            dec_kind = OPK_NONE;
        end
        // bank bit sits at bit 8 for every file form here
        // indexed offsets wrap inside the 12-bit space, no bank consulted
        if (instr[8]) begin
            dec_addr = {bank_r, f_field}; // RQ4
        end else if (ext_r && f_field <= INDEX_LIMIT) begin
            dec_addr = index_r + {4'h0, f_field}; // RQ5
        end else if (f_field < ACCESS_SPLIT) begin
            dec_addr = {4'h0, f_field}; // RQ4
        end else begin
            dec_addr = {SFR_BANK, f_field}; // RQ4
        end
    end

    // arithmetic for the process and write phases
    logic [8:0] sum9;
    logic [4:0] half5;
    logic [7:0] and_src;
    logic [7:0] clr_mask;
    logic [PC_W-1:0] offset2;

    always_comb begin
        sum9 = {1'b0, acc_r} + {1'b0, dmem_rdata}
            + {8'h00, status_r[FLAG_C]}; // RQ1
        // half carry is the carry out of the low nibble
        half5 = {1'b0, acc_r[3:0]} + {1'b0, dmem_rdata[3:0]}
            + {4'h0, status_r[FLAG_C]};
        and_src = (kind_r == OPK_ANDI) ? ir_r[7:0] : dmem_rdata;
        clr_mask = ~(8'h01 << ir_r[11:9]); // RQ13
        // sign-extended offset, doubled
        offset2 = PC_W'({{(PC_W - 8){ir_r[7]}}, ir_r[7:0]} << 1); // RQ11
    end

    // sequencer and datapath
    always_comb begin
        phase_nxt = phase_r;
        nop_nxt = nop_r;
        ir_nxt = ir_r;
        kind_nxt = kind_r;
        here_nxt = here_r;
        res_nxt = res_r;
        flags_nxt = flags_r;
        take_nxt = take_r;
        acc_nxt = acc_r;
        bank_nxt = bank_r;
        status_nxt = status_r;
        pc_nxt = pc_r;
        ext_nxt = ext_r;
        index_nxt = index_r;
        dreq_nxt = dreq_r;
        dreq_nxt.rd = 1'b0;
        dreq_nxt.wr = 1'b0;
        unk_nxt = 1'b0;

        // software writes; the core's own write-back below overrides them
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_ACC: acc_nxt = reg_wdata[7:0];
                OFS_BANK: bank_nxt = reg_wdata[3:0];
                OFS_STATUS: status_nxt = reg_wdata[4:0];
                OFS_PC: pc_nxt = reg_wdata[PC_W-1:0];
                OFS_CTRL: ext_nxt = reg_wdata[CTRL_EXT];
                OFS_INDEX: index_nxt = reg_wdata[11:0];
                default: ;
            endcase
        end

        unique case (phase_r)
            PH_IDLE: begin
                phase_nxt = PH_DECODE;
            end
            PH_DECODE: begin
                // the no-op cycle after a taken branch refuses new words
                if (nop_r) begin
                    phase_nxt = PH_READ; // RQ12
                end else if (instr_valid) begin
                    ir_nxt = instr;
                    kind_nxt = dec_kind;
                    here_nxt = pc_r;
                    pc_nxt = pc_r + PC_W'(PC_STEP);
                    unk_nxt = (dec_kind == OPK_NONE);
                    dreq_nxt.addr = dec_addr;
                    dreq_nxt.rd = (dec_kind == OPK_ADDC) ||
                        (dec_kind == OPK_ANDF) ||
                        (dec_kind == OPK_CLRBIT); // RQ15
                    phase_nxt = PH_READ;
                end
            end
            PH_READ: begin
                phase_nxt = PH_PROCESS;
            end
            PH_PROCESS: begin
                phase_nxt = PH_WRITE;
                // flags start from status so untouched bits keep their value
                flags_nxt = status_r;
                take_nxt = 1'b0;
                if (!nop_r) begin
                    unique case (kind_r)
                        OPK_ADDC: begin
                            res_nxt = sum9[7:0];
                            flags_nxt[FLAG_C] = sum9[8]; // RQ2
                            flags_nxt[FLAG_HALF] = half5[4];
                            flags_nxt[FLAG_Z] = (sum9[7:0] == 8'h00);
                            flags_nxt[FLAG_N] = sum9[7];
                            flags_nxt[FLAG_WRAP] =
                                (acc_r[7] == dmem_rdata[7]) &&
                                (sum9[7] != acc_r[7]);
                        end
                        OPK_ANDI, OPK_ANDF: begin
                            res_nxt = acc_r & and_src; // RQ6 RQ7
                            flags_nxt[FLAG_Z] =
                                ((acc_r & and_src) == 8'h00); // RQ8
                            flags_nxt[FLAG_N] = acc_r[7] & and_src[7];
                        end
                        OPK_BRANCH: begin
                            // bit 10 picks the sign test over carry
                            take_nxt = ir_r[10] ? status_r[FLAG_N]
                                : status_r[FLAG_C]; // RQ9 RQ10
                        end
                        OPK_CLRBIT: begin
                            res_nxt = dmem_rdata & clr_mask; // RQ13
                        end
                        OPK_NONE: ;
                    endcase
                    // write strobe lands in the last phase
                    if (kind_r == OPK_CLRBIT ||
                        ((kind_r == OPK_ADDC || kind_r == OPK_ANDF) &&
                         ir_r[9])) begin
                        dreq_nxt.wr = 1'b1; // RQ3 RQ15
                        dreq_nxt.wdata = (kind_r == OPK_CLRBIT)
                            ? (dmem_rdata & clr_mask)
                            : ((kind_r == OPK_ADDC) ? sum9[7:0]
                                : (acc_r & dmem_rdata));
                    end
                end
            end
            PH_WRITE: begin
                phase_nxt = PH_DECODE;
                if (nop_r) begin
                    nop_nxt = 1'b0; // RQ12
                end else begin
                    unique case (kind_r)
                        OPK_ADDC, OPK_ANDF: begin
                            if (!ir_r[9]) begin
                                acc_nxt = res_r; // RQ3
                            end
                            status_nxt = flags_r; // RQ2 RQ8
                        end
                        OPK_ANDI: begin
                            acc_nxt = res_r; // RQ6
                            status_nxt = flags_r; // RQ8
                        end
                        OPK_BRANCH: begin
                            // status untouched here and for bit clear
                            if (take_r) begin
                                pc_nxt = here_r + PC_W'(PC_STEP)
                                    + offset2; // RQ11 RQ14
                                nop_nxt = 1'b1; // RQ12
                            end
                        end
                        OPK_CLRBIT, OPK_NONE: ; // RQ14
                    endcase
                end
            end
            default: begin
                phase_nxt = PH_IDLE;
            end
        endcase
    end

    // outputs and register read port
    always_comb begin
        // ready looks one edge ahead so the registered pin is in step
        ready_nxt = (phase_nxt == PH_DECODE) && !nop_nxt;
        // read data stand for one cycle, then return to zero
        rdata_nxt = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_ACC: rdata_nxt = {24'h00_0000, acc_r};
                OFS_BANK: rdata_nxt = {28'h000_0000, bank_r};
                OFS_STATUS: rdata_nxt = {27'h000_0000, status_r};
                OFS_PC: rdata_nxt = 32'(pc_r);
                OFS_CTRL: rdata_nxt = {31'h0000_0000, ext_r};
                OFS_INDEX: rdata_nxt = {20'h0_0000, index_r};
                OFS_STATE: rdata_nxt = {25'h000_0000, kind_r, nop_r,
                    phase_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // architectural registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            acc_r <= ACC_RST;
            bank_r <= BANK_RST;
            status_r <= STATUS_RST;
            pc_r <= PC_W'(PC_RST);
            ext_r <= 1'b0;
            index_r <= INDEX_RST;
        end else begin
            acc_r <= acc_nxt;
            bank_r <= bank_nxt;
            status_r <= status_nxt;
            pc_r <= pc_nxt;
            ext_r <= ext_nxt;
            index_r <= index_nxt;
        end
    end

    // sequencer registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= PH_IDLE;
            nop_r <= 1'b0;
            ir_r <= 16'h0000;
            kind_r <= OPK_NONE;
            here_r <= '0;
            res_r <= 8'h00;
            flags_r <= STATUS_RST;
            take_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            nop_r <= nop_nxt;
            ir_r <= ir_nxt;
            kind_r <= kind_nxt;
            here_r <= here_nxt;
            res_r <= res_nxt;
            flags_r <= flags_nxt;
            take_r <= take_nxt;
        end
    end

    // instruction port and data memory outputs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ready_r <= 1'b0;
            dreq_r <= '0;
            unk_r <= 1'b0;
        end else begin
            ready_r <= ready_nxt;
            dreq_r <= dreq_nxt;
            unk_r <= unk_nxt;
        end
    end

    // register port read data
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign instr_ready = ready_r;
    assign prog_addr = pc_r;
    assign dmem_req = dreq_r;
    assign reg_rdata = rdata_r;
    assign unknown_op = unk_r;

endmodule

`default_nettype wire

/* File: exec_mem_model.sv */
// data memory partner: one byte per address, read answered next cycle
// assumes requests arrive on the execute block's dmem_req carrier
`timescale 1ns/100ps
`default_nettype none
module exec_mem_model
    import exec_pkg::*;
(
    input wire logic clock,
    input wire dmem_req_t req,
    output logic [7:0] rdata
);
    logic [7:0] mem [4096];
    initial rdata = 8'h00;
    // outside a read answer the bus shows the inverse, so no stale byte helps
    always @(posedge clock) begin
        if (req.wr)
            mem[req.addr] <= req.wdata;
        rdata <= req.rd ? mem[req.addr] : ~rdata;
    end
endmodule
`default_nettype wire

/* File: alu_branch_bitclear_exec_props.sv */
// port assertions for the execute block
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module alu_branch_bitclear_exec_props
    import exec_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int PC_W = 21
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [PC_W-1:0] prog_addr,
    input wire dmem_req_t dmem_req,
    input wire logic [7:0] dmem_rdata,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic unknown_op
);
    logic take, br, filef;
    logic [PC_W-1:0] base_r, tgt;
    logic [7:0] off_r;
    logic [2:0] bit_r;
    logic [3:0] bank_r;
    logic odd;
    assign take = instr_ready && instr_valid;
    assign br = take && (instr[15:8] == OP_BR_CARRY
        || instr[15:8] == OP_BR_SIGN);
    assign filef = take && (instr[15:10] == OP_ADDC_FILE
        || instr[15:10] == OP_AND_FILE || instr[15:12] == OP_CLR_BIT);
    assign odd = take && !(br || filef || instr[15:8] == OP_AND_IMM);
    assign tgt = base_r + PC_W'(2) + PC_W'($signed({off_r, 1'b0}));
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            base_r <= '0;
            off_r <= '0;
            bit_r <= '0;
            bank_r <= BANK_RST;
        end else begin
            if (take) begin
                base_r <= prog_addr;
                off_r <= instr[7:0];
                bit_r <= instr[11:9];
            end
            if (reg_wr && reg_addr == OFS_BANK)
                bank_r <= reg_wdata[3:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_untaken;
        ##4 instr_ready && prog_addr == base_r + PC_W'(2);
    endsequence
    sequence s_taken;
        ##4 !instr_ready && prog_addr == tgt ##4 instr_ready;
    endsequence
    AST_PC_STEP: assert property (
        take |=> prog_addr == $past(prog_addr) + PC_W'(2))
        else $error("pc did not step by two on take");
    AST_READY_GAP: assert property (
        take |=> !instr_ready [*3])
        else $error("ready returned early");
    AST_FILE_RD: assert property (
        filef |=> dmem_req.rd && !dmem_req.wr)
        else $error("file operand not read");
    AST_BANK_ADDR: assert property (
        filef && instr[8] |=> dmem_req.addr == {$past(bank_r), off_r})
        else $error("banked address wrong");
    AST_IMM_QUIET: assert property (
        take && instr[15:8] == OP_AND_IMM
            |=> (!dmem_req.rd && !dmem_req.wr) [*3])
        else $error("immediate form touched memory");
    AST_CLR_DATA: assert property (
        take && instr[15:12] == OP_CLR_BIT |-> ##3 (dmem_req.wr
            && dmem_req.wdata == ($past(dmem_rdata) & ~(8'h01 << bit_r))))
        else $error("bit clear wrote wrong byte");
    AST_BR_FLOW: assert property (
        br |-> s_untaken or s_taken)
        else $error("branch timing or target wrong");
    // an untaken branch may be followed at once by a file instruction
    AST_BR_QUIET: assert property (
        br |=> (!dmem_req.rd && !dmem_req.wr) [*3]
            ##1 (instr_ready or (!dmem_req.rd && !dmem_req.wr) [*4]))
        else $error("branch touched memory");
    AST_UNK_PULSE: assert property (
        unknown_op == $past(odd))
        else $error("unknown word flag wrong");
endmodule
bind alu_branch_bitclear_exec alu_branch_bitclear_exec_props #(.ADDR_W(ADDR_W),
    .PC_W(PC_W)) i_props (.clock, .reset_n, .instr, .instr_valid,
    .instr_ready, .prog_addr, .dmem_req, .dmem_rdata, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .unknown_op);
`default_nettype wire

/* File: alu_branch_bitclear_exec_bench.sv */
// self-checking bench for the execute block beside a data memory model
// assumes default widths and registers reachable while the core is idle
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module alu_branch_bitclear_exec_bench
    import exec_pkg::*;
;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic instr_valid = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic instr_ready, unknown_op;
    logic [20:0] prog_addr, pc;
    dmem_req_t dmem_req;
    logic [7:0] dmem_rdata, w, v, f, n, r;
    logic [31:0] reg_rdata, rd;
    logic [4:0] st;
    logic [3:0] bk;
    logic [12:0] e;
    logic [11:0] ea;
    int miscompares = 0;
    int n_tests = 0;
    int cyc;
    int n_unk = 0;
    always #25 clock = ~clock;
    // counts unknown-word pulses over the whole run
    always @(posedge clock) begin
        if (unknown_op === 1'b1)
            n_unk++;
    end
    alu_branch_bitclear_exec i_dut (.clock, .reset_n, .instr, .instr_valid,
        .instr_ready, .prog_addr, .dmem_req, .dmem_rdata, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .unknown_op);
    exec_mem_model i_mem (.clock, .req(dmem_req), .rdata(dmem_rdata));
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rreg(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        rd = reg_rdata;
    endtask
    // cyc counts edges from the take until ready is seen again
    task automatic run(input logic [15:0] word);
        instr <= word;
        instr_valid <= 1'b1;
        cyc = 0;
        @(posedge clock);
        while (!instr_ready && cyc < 40) begin
            @(posedge clock);
            cyc++;
        end
        instr_valid <= 1'b0;
        cyc = 0;
        @(posedge clock);
        while (!instr_ready && cyc < 40) begin
            @(posedge clock);
            cyc++;
        end
    endtask
    task automatic prep;
        {w, v, f} = 24'($urandom);
        {st, bk} = 9'($urandom);
    endtask
    task automatic load;
        wreg(OFS_ACC, {24'h0, w});
        wreg(OFS_STATUS, {27'h0, st});
        wreg(OFS_BANK, {28'h0, bk});
        i_mem.mem[{bk, f}] = v;
    endtask
    function automatic logic [12:0] addc(input logic [7:0] a, b,
        input logic c);
        logic [8:0] s;
        logic h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, c};
        h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c}) > 5'h0f;
        return {s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, h, s};
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #1_000_000;
        miscompares++;
        $display("ERROR t=%0t watchdog %h %h", $time, n_tests, 0);
        conclude;
    end
    initial begin
        void'($urandom(32'h0000_04c9));
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rreg(OFS_STATUS);
        `CHK(rd, {27'h0, STATUS_RST})
        rreg(OFS_PC);
        `CHK(rd, {11'h0, PC_RST})
        rreg(8'h40);
        `CHK(rd, 32'h0000_0000)
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            prep;
            // carry ripple to zero, then signed wrap
            if (i < 2) begin
                {w, v, st[FLAG_C]} = i ? {8'h7F, 8'h00, 1'b1}
                    : {8'hFF, 8'h00, 1'b1};
            end
            load;
            run({OP_ADDC_FILE, i[0], 1'b1, f});
            e = addc(w, v, st[FLAG_C]);
            rreg(OFS_STATUS);
            `CHK(rd[4:0], e[12:8])
            rreg(OFS_ACC);
            `CHK(rd[7:0], i[0] ? w : e[7:0])
            `CHK(i_mem.mem[{bk, f}], i[0] ? e[7:0] : v)
        end
        $display("test add with carry done");
        for (int i = 0; i < 8; i++) begin
            prep;
            v = i < 2 ? 8'h00 : v;
            load;
            run(i[0] ? {OP_AND_FILE, i[1], 1'b1, f} : {OP_AND_IMM, v});
            r = w & v;
            rreg(OFS_ACC);
            `CHK(rd[7:0], i[0] && i[1] ? w : r)
            `CHK(i_mem.mem[{bk, f}], i[0] && i[1] ? r : v)
            rreg(OFS_STATUS);
            `CHK(rd[4:0], {r[7], st[3], r == 8'h00, st[1:0]})
        end
        $display("test and done");
        wreg(OFS_INDEX, 32'h0000_0123);
        for (int i = 0; i < 4; i++) begin
            prep;
            f = i[0] ? 8'h60 : INDEX_LIMIT;
            ea = i[1] && !i[0] ? 12'h123 + {4'h0, f} :
                (f < ACCESS_SPLIT ? {4'h0, f} : {SFR_BANK, f});
            w = 8'hFF;
            load;
            i_mem.mem[ea] = v;
            wreg(OFS_CTRL, {31'h0, i[1]});
            run({OP_AND_FILE, 2'b00, f});
            rreg(OFS_ACC);
            `CHK(rd[7:0], v)
        end
        wreg(OFS_CTRL, 32'h0000_0000);
        $display("test addressing done");
        for (int b = 0; b < 8; b++) begin
            prep;
            load;
            run({OP_CLR_BIT, 3'(b), 1'b1, f});
            `CHK(i_mem.mem[{bk, f}], v & ~(8'h01 << b))
            rreg(OFS_STATUS);
            `CHK(rd[4:0], st)
        end
        $display("test bit clear done");
        prep;
        load;
        run(16'hFFFF);
        `CHK(cyc, 3)
        `CHK(n_unk, 1)
        rreg(OFS_ACC);
        `CHK(rd[7:0], w)
        $display("test unknown word done");
        for (int i = 0; i < 8; i++) begin
            prep;
            n = i < 2 ? 8'h80 : (i < 4 ? 8'h7F : w);
            // both offset extremes are taken; the last two stay untaken
            st[i[0] ? FLAG_N : FLAG_C] = !(i[1] && i[2]);
            wreg(OFS_STATUS, {27'h0, st});
            wreg(OFS_PC, 32'h0000_1000);
            run({i[0] ? OP_BR_SIGN : OP_BR_CARRY, n});
            `CHK(cyc, i[1] && i[2] ? 3 : 7)
            pc = 21'h00_1002
                + (i[1] && i[2] ? 21'h0 : {{12{n[7]}}, n, 1'b0});
            rreg(OFS_PC);
            `CHK(rd[20:0], pc)
            rreg(OFS_STATUS);
            `CHK(rd[4:0], st)
        end
        $display("test branch done");
        conclude;
    end
endmodule
`default_nettype wire
